// file: two_wire_pkg.sv
// Constants and types for the two-wire slave engine.
// Assumes the engine, its checker and its bench read them as two_wire_pkg::name.
package two_wire_pkg;

  // ------------------------------------------------------------
  // Link state machine
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ACK, S_WAIT, S_RX, S_TX, S_MACK
  } link_state_type;

  typedef enum logic [1:0] {
    W_RX, W_ACK_TX, W_TX, W_IDLE
  } wait_next_type;

  // ------------------------------------------------------------
  // Status codes
  // ------------------------------------------------------------
  localparam logic [7:0] ST_NONE = 8'hf8;
  localparam logic [7:0] ST_WRITE_ACK = 8'h60;
  localparam logic [7:0] ST_WRITE_ARB = 8'h68;
  localparam logic [7:0] ST_GC_ACK = 8'h70;
  localparam logic [7:0] ST_GC_ARB = 8'h78;
  localparam logic [7:0] ST_RX_ACK = 8'h80;
  localparam logic [7:0] ST_RX_NACK = 8'h88;
  localparam logic [7:0] ST_GC_RX_ACK = 8'h90;
  localparam logic [7:0] ST_GC_RX_NACK = 8'h98;
  localparam logic [7:0] ST_STOP_RESTART = 8'ha0;
  localparam logic [7:0] ST_READ_ACK = 8'ha8;
  localparam logic [7:0] ST_READ_ARB = 8'hb0;
  localparam logic [7:0] ST_TX_ACK = 8'hb8;
  localparam logic [7:0] ST_TX_NACK = 8'hc0;
  localparam logic [7:0] ST_TX_LAST = 8'hc8;

  // ------------------------------------------------------------
  // Framing
  // ------------------------------------------------------------
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] FIRST_BIT = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;

endpackage

// file: two_wire_slave_engine.sv
// Slave engine for a two-wire serial bus: address match, receive,
// transmit, clock stretching and status codes.
// Assumes SCL/SDA pins with external pull-ups, an oversampling link
// clock much faster than SCL, and CPU control on clk.
//
// How it works
// - Setting the enable bit puts the engine in not-addressed slave state.
// - Clearing enable freezes internal state except bus-busy tracking; only the SDA and SCL drives are released.
// - Deep sleep loses everything; software reprograms after wake-up.
// - Bytes move one bit per master clock pulse, MSB first.
// - First byte after START is 7-bit address plus direction bit.
// - Receiver drives the acknowledge bit on the ninth SCL pulse.
// - START is SDA falling with SCL high; STOP is SDA rising.
// - SDA changes only while SCL is low.
// - Repeated START restarts address phase without a STOP.
// - Own or enabled general-call address match sets the event flag.
// - Own address with read direction enters slave transmitter mode.
// - Read request holds SCL low until first byte is written.
// - After master ACK, SCL held low until new data is written.
// - Master NACK returns transmitter to not-addressed state.
// - Status 0xA8 after own read address, 0xB0 after lost arbitration.
// - Transmit status 0xB8 ack, 0xC0 nack, 0xC8 last byte acked.
// - Byte loaded with ack enable clear is the final byte.
// - Recognition follows ack enable; begin request waits for free bus.
// - Own address with write direction enters slave receiver mode.
// - Each received byte sets the event flag and is acknowledged while ack enable is set.
// - SCL held low while the event flag stays set, except after STOP or repeated START.
// - STOP during a transfer to this slave sets the halt flag.
// - Repeated START while addressed returns to address reception.
// - Status 0xA0 on STOP or repeated START while addressed.

`timescale 1ns/100ps
`default_nettype none

module two_wire_slave_engine (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic module_enable_bit,
  input wire logic ack_enable_bit,
  input wire logic begin_request_bit,
  input wire logic general_call_enable,
  input wire logic [6:0] own_address_register,
  input wire logic arb_lost,
  input wire logic [7:0] data_register_in,
  input wire logic data_write,
  input wire logic event_clear,
  input wire logic halt_clear,
  output logic event_flag,
  output logic halt_request_flag,
  output logic [7:0] status_code_field,
  output logic [7:0] data_register_out,
  output logic begin_pending,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  // Link domain
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic en_s1_q, en_s2_q, en_s3_q;
  logic acken_s1_q, acken_s2_q;
  logic beg_s1_q, beg_s2_q;
  logic arb_s1_q, arb_s2_q;
  logic rel_s1_q, rel_s2_q, rel_s3_q;
  two_wire_pkg::link_state_type state_q;
  two_wire_pkg::wait_next_type wait_next_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, tx_sh_q, pend_status_q, status_lk_q, rx_lk_q;
  logic [6:0] own_lk_q;
  logic tx_last_q, gc_mode_q, ack_to_tx_q, master_ack_q, gc_lk_q;
  logic ev_tgl_q, halt_tgl_q, sda_oe_q, scl_oe_q, scl_out_q, sda_out_q;
  logic bus_busy_q, begin_due_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic en_rise, rel_edge, addressed, own_hit, gc_hit;
  // System domain
  logic ev_s1_q, ev_s2_q, ev_s3_q;
  logic halt_s1_q, halt_s2_q, halt_s3_q;
  logic due_s1_q, due_s2_q;
  logic event_flag_q, halt_flag_q, ack_cap_q, rel_tgl_q, gc_q;
  logic [7:0] status_q, rx_data_q, tx_q;
  logic [6:0] own_q;
  logic ev_edge, halt_edge, release_req;

  // ------------------------------------------------------------
  // Link synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      en_s3_q <= 1'b0;
      acken_s1_q <= 1'b0;
      acken_s2_q <= 1'b0;
      beg_s1_q <= 1'b0;
      beg_s2_q <= 1'b0;
      arb_s1_q <= 1'b0;
      arb_s2_q <= 1'b0;
      rel_s1_q <= 1'b0;
      rel_s2_q <= 1'b0;
      rel_s3_q <= 1'b0;
    end else begin
      en_s1_q <= module_enable_bit;
      en_s2_q <= en_s1_q;
      en_s3_q <= en_s2_q;
      acken_s1_q <= ack_enable_bit;
      acken_s2_q <= acken_s1_q;
      beg_s1_q <= begin_request_bit;
      beg_s2_q <= beg_s1_q;
      arb_s1_q <= arb_lost;
      arb_s2_q <= arb_s1_q;
      rel_s1_q <= rel_tgl_q;
      rel_s2_q <= rel_s1_q;
      rel_s3_q <= rel_s2_q;
    end
  end

  // ------------------------------------------------------------
  // Bus conditions
  // ------------------------------------------------------------
  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  // Both samples high keeps a slow SCL edge from faking a condition
  assign start_det = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
  assign stop_det = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;
  assign en_rise = en_s2_q & ~en_s3_q;
  assign rel_edge = rel_s2_q ^ rel_s3_q;
  assign addressed = (state_q != two_wire_pkg::S_IDLE) &&
                     (state_q != two_wire_pkg::S_ADDR);
  assign own_hit = acken_s2_q && (sh_q[7:1] == own_lk_q);
  assign gc_hit = acken_s2_q && gc_lk_q && !sh_q[0] &&
                  (sh_q[7:1] == two_wire_pkg::GENERAL_CALL_ADDR);

  // ------------------------------------------------------------
  // Link state machine
  // ------------------------------------------------------------
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= two_wire_pkg::S_IDLE;
      wait_next_q <= two_wire_pkg::W_IDLE;
      cnt_q <= two_wire_pkg::CNT_ZERO;
      sh_q <= two_wire_pkg::BYTE_RESET;
      tx_sh_q <= two_wire_pkg::BYTE_RESET;
      tx_last_q <= 1'b0;
      gc_mode_q <= 1'b0;
      ack_to_tx_q <= 1'b0;
      master_ack_q <= 1'b0;
      pend_status_q <= two_wire_pkg::ST_NONE;
      own_lk_q <= 7'h00;
      gc_lk_q <= 1'b0;
      status_lk_q <= two_wire_pkg::ST_NONE;
      rx_lk_q <= two_wire_pkg::BYTE_RESET;
      ev_tgl_q <= 1'b0;
      halt_tgl_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (en_rise) begin
      // Config is stable while enable is being raised
      state_q <= two_wire_pkg::S_IDLE;
      sda_oe_q <= 1'b0;
      cnt_q <= two_wire_pkg::CNT_ZERO;
      own_lk_q <= own_q;
      gc_lk_q <= gc_q;
    end else if (!en_s2_q) begin
      sda_oe_q <= 1'b0;
    end else if (start_det) begin
      if (addressed) begin
        status_lk_q <= two_wire_pkg::ST_STOP_RESTART;
        ev_tgl_q <= ~ev_tgl_q;
      end
      state_q <= two_wire_pkg::S_ADDR;
      cnt_q <= two_wire_pkg::CNT_ZERO;
      sda_oe_q <= 1'b0;
    end else if (stop_det) begin
      if (addressed) begin
        status_lk_q <= two_wire_pkg::ST_STOP_RESTART;
        ev_tgl_q <= ~ev_tgl_q;
        halt_tgl_q <= ~halt_tgl_q;
      end
      state_q <= two_wire_pkg::S_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      unique case (state_q)
        two_wire_pkg::S_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        two_wire_pkg::S_ADDR: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s2_q};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == two_wire_pkg::BYTE_BITS) begin
            cnt_q <= two_wire_pkg::CNT_ZERO;
            if (own_hit && sh_q[0]) begin
              // Stretch before acknowledging until a byte is loaded
              status_lk_q <= arb_s2_q ? two_wire_pkg::ST_READ_ARB
                                      : two_wire_pkg::ST_READ_ACK;
              ev_tgl_q <= ~ev_tgl_q;
              wait_next_q <= two_wire_pkg::W_ACK_TX;
              state_q <= two_wire_pkg::S_WAIT;
            end else if (own_hit || gc_hit) begin
              gc_mode_q <= ~own_hit;
              ack_to_tx_q <= 1'b0;
              sda_oe_q <= 1'b1;
              if (own_hit) begin
                pend_status_q <= arb_s2_q ? two_wire_pkg::ST_WRITE_ARB
                                          : two_wire_pkg::ST_WRITE_ACK;
              end else begin
                pend_status_q <= arb_s2_q ? two_wire_pkg::ST_GC_ARB
                                          : two_wire_pkg::ST_GC_ACK;
              end
              wait_next_q <= two_wire_pkg::W_RX;
              state_q <= two_wire_pkg::S_ACK;
            end else begin
              state_q <= two_wire_pkg::S_IDLE;
            end
          end
        end
        two_wire_pkg::S_ACK: begin
          if (scl_fall) begin
            if (ack_to_tx_q) begin
              sda_oe_q <= ~tx_sh_q[7];
              tx_sh_q <= {tx_sh_q[6:0], 1'b0};
              cnt_q <= two_wire_pkg::FIRST_BIT;
              state_q <= two_wire_pkg::S_TX;
            end else begin
              sda_oe_q <= 1'b0;
              status_lk_q <= pend_status_q;
              ev_tgl_q <= ~ev_tgl_q;
              state_q <= two_wire_pkg::S_WAIT;
            end
          end
        end
        two_wire_pkg::S_RX: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s2_q};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == two_wire_pkg::BYTE_BITS) begin
            rx_lk_q <= sh_q;
            cnt_q <= two_wire_pkg::CNT_ZERO;
            ack_to_tx_q <= 1'b0;
            sda_oe_q <= acken_s2_q;
            if (gc_mode_q) begin
              pend_status_q <= acken_s2_q ? two_wire_pkg::ST_GC_RX_ACK
                                          : two_wire_pkg::ST_GC_RX_NACK;
            end else begin
              pend_status_q <= acken_s2_q ? two_wire_pkg::ST_RX_ACK
                                          : two_wire_pkg::ST_RX_NACK;
            end
            wait_next_q <= acken_s2_q ? two_wire_pkg::W_RX
                                      : two_wire_pkg::W_IDLE;
            state_q <= two_wire_pkg::S_ACK;
          end
        end
        two_wire_pkg::S_TX: begin
          if (scl_fall) begin
            if (cnt_q == two_wire_pkg::BYTE_BITS) begin
              sda_oe_q <= 1'b0;
              state_q <= two_wire_pkg::S_MACK;
            end else begin
              sda_oe_q <= ~tx_sh_q[7];
              tx_sh_q <= {tx_sh_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        two_wire_pkg::S_MACK: begin
          if (scl_rise) begin
            master_ack_q <= ~sda_s2_q;
          end else if (scl_fall) begin
            if (!master_ack_q) begin
              status_lk_q <= two_wire_pkg::ST_TX_NACK;
              wait_next_q <= two_wire_pkg::W_IDLE;
            end else if (tx_last_q) begin
              status_lk_q <= two_wire_pkg::ST_TX_LAST;
              wait_next_q <= two_wire_pkg::W_IDLE;
            end else begin
              status_lk_q <= two_wire_pkg::ST_TX_ACK;
              wait_next_q <= two_wire_pkg::W_TX;
            end
            ev_tgl_q <= ~ev_tgl_q;
            state_q <= two_wire_pkg::S_WAIT;
          end
        end
        two_wire_pkg::S_WAIT: begin
          if (rel_edge) begin
            tx_last_q <= ~ack_cap_q;
            unique case (wait_next_q)
              two_wire_pkg::W_RX: begin
                cnt_q <= two_wire_pkg::CNT_ZERO;
                state_q <= two_wire_pkg::S_RX;
              end
              two_wire_pkg::W_ACK_TX: begin
                tx_sh_q <= tx_q;
                ack_to_tx_q <= 1'b1;
                sda_oe_q <= 1'b1;
                state_q <= two_wire_pkg::S_ACK;
              end
              two_wire_pkg::W_TX: begin
                sda_oe_q <= ~tx_q[7];
                tx_sh_q <= {tx_q[6:0], 1'b0};
                cnt_q <= two_wire_pkg::FIRST_BIT;
                state_q <= two_wire_pkg::S_TX;
              end
              two_wire_pkg::W_IDLE: begin
                state_q <= two_wire_pkg::S_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  // Stretch by holding SCL low while software owes an answer
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_oe_q <= 1'b0;
      scl_out_q <= 1'b0;
      sda_out_q <= 1'b0;
    end else begin
      scl_oe_q <= en_s2_q && (state_q == two_wire_pkg::S_WAIT) &&
                  !rel_edge;
      scl_out_q <= 1'b0;
      sda_out_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Bus busy and begin request
  // ------------------------------------------------------------
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_busy_q <= 1'b0;
      begin_due_q <= 1'b0;
    end else begin
      if (start_det) begin
        bus_busy_q <= 1'b1;
      end else if (stop_det) begin
        bus_busy_q <= 1'b0;
      end
      begin_due_q <= en_s2_q && beg_s2_q && !bus_busy_q &&
                     (state_q == two_wire_pkg::S_IDLE);
    end
  end

  // ------------------------------------------------------------
  // System side synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_s1_q <= 1'b0;
      ev_s2_q <= 1'b0;
      ev_s3_q <= 1'b0;
      halt_s1_q <= 1'b0;
      halt_s2_q <= 1'b0;
      halt_s3_q <= 1'b0;
      due_s1_q <= 1'b0;
      due_s2_q <= 1'b0;
    end else begin
      ev_s1_q <= ev_tgl_q;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
      halt_s1_q <= halt_tgl_q;
      halt_s2_q <= halt_s1_q;
      halt_s3_q <= halt_s2_q;
      due_s1_q <= begin_due_q;
      due_s2_q <= due_s1_q;
    end
  end

  assign ev_edge = ev_s2_q ^ ev_s3_q;
  assign halt_edge = halt_s2_q ^ halt_s3_q;
  // A clear landing on a fresh event is dropped, so no stale release
  assign release_req = data_write ||
                       (event_clear && event_flag_q && !ev_edge);

  // ------------------------------------------------------------
  // Event and halt flags
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_flag_q <= 1'b0;
    end else if (ev_edge) begin
      event_flag_q <= 1'b1;
    end else if (event_clear || data_write) begin
      event_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_flag_q <= 1'b0;
    end else if (halt_edge) begin
      halt_flag_q <= 1'b1;
    end else if (halt_clear) begin
      halt_flag_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Status and received data
  // ------------------------------------------------------------
  // Link words are held still until the next event toggle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= two_wire_pkg::ST_NONE;
      rx_data_q <= two_wire_pkg::BYTE_RESET;
    end else if (ev_edge) begin
      status_q <= status_lk_q;
      rx_data_q <= rx_lk_q;
    end
  end

  // ------------------------------------------------------------
  // Transmit data, configuration and release
  // ------------------------------------------------------------
  // Reset doubles as deep-sleep loss of configuration and state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= two_wire_pkg::BYTE_RESET;
      ack_cap_q <= 1'b0;
      rel_tgl_q <= 1'b0;
      own_q <= 7'h00;
      gc_q <= 1'b0;
    end else begin
      own_q <= own_address_register;
      gc_q <= general_call_enable;
      if (data_write) begin
        tx_q <= data_register_in;
      end
      if (release_req) begin
        ack_cap_q <= ack_enable_bit;
        rel_tgl_q <= ~rel_tgl_q;
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign event_flag = event_flag_q;
  assign halt_request_flag = halt_flag_q;
  assign status_code_field = status_q;
  assign data_register_out = rx_data_q;
  assign begin_pending = due_s2_q;
  assign scl_out = scl_out_q;
  assign scl_oe = scl_oe_q;
  assign sda_out = sda_out_q;
  assign sda_oe = sda_oe_q;

endmodule // two_wire_slave_engine

`default_nettype wire

// file: two_wire_slave_engine_monitor.sv
// Port checker for the two-wire slave engine.
// Assumes bind to every engine instance; sees only the engine's ports.
`timescale 1ns/100ps
`default_nettype none
module two_wire_slave_engine_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic event_clear,
  input wire logic data_write,
  input wire logic halt_clear,
  input wire logic event_flag,
  input wire logic halt_request_flag,
  input wire logic [7:0] status_code_field,
  input wire logic [7:0] data_register_out,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Stop or restart events never stretch, so they are left out
  sequence held_ev;
    event_flag && status_code_field != two_wire_pkg::ST_STOP_RESTART;
  endsequence
  a_pins_low: assert property (
    @(posedge clk) disable iff (!rst_n) !scl_out && !sda_out)
    else $error("pin output not low");
  a_flag_fell: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(event_flag) |-> $past(event_clear) || $past(data_write))
    else $error("event flag dropped on its own");
  a_stretch_held: assert property (
    @(posedge clk) disable iff (!rst_n) held_ev [*4] |-> scl_oe)
    else $error("clock not held with event pending");
  a_halt_rose: assert property (
    @(posedge clk) disable iff (!rst_n) $rose(halt_request_flag) |->
    ##[0:3] event_flag && status_code_field == 8'ha0)
    else $error("halt flag without stop status");
  a_halt_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    halt_request_flag && !halt_clear |=> halt_request_flag)
    else $error("halt flag lost without clear");
  a_status_event: assert property (
    @(posedge clk) disable iff (!rst_n)
    $changed(status_code_field) |-> ##[0:1] event_flag)
    else $error("status moved without event");
  a_data_event: assert property (
    @(posedge clk) disable iff (!rst_n)
    $changed(data_register_out) |-> ##[0:1] event_flag)
    else $error("data moved without event");
  a_sda_scl_low: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    $changed(sda_oe) |-> !$past(scl_in))
    else $error("data pin moved while clock high");
endmodule // two_wire_slave_engine_monitor
bind two_wire_slave_engine two_wire_slave_engine_monitor u_monitor (
  .clk, .rst_n, .link_clk, .event_clear, .data_write, .halt_clear,
  .event_flag, .halt_request_flag, .status_code_field,
  .data_register_out, .scl_in, .scl_out, .scl_oe, .sda_out, .sda_oe
);
`default_nettype wire

// file: two_wire_master_model.sv
// Behavioural bus master facing the slave engine.
// Assumes the bench resolves both pins as wired-AND with pull-ups.
`timescale 1ns/100ps
`default_nettype none
module two_wire_master_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe
);
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // Long bit time keeps the slave's sync delay well inside a phase
  localparam int T = 600;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // Data moves with clock low; release waits out any stretch
  task automatic hi(input logic b);
    #(T / 4);
    sda_oe = ~b;
    #(T / 2);
    scl_oe = 1'b0;
    wait (scl === 1'b1);
    #T;
  endtask
  task automatic bit_io(input logic b, output logic r);
    hi(b);
    r = sda;
    scl_oe = 1'b1;
  endtask
  task automatic start;
    hi(1'b1);
    sda_oe = 1'b1;
    #T;
    scl_oe = 1'b1;
  endtask
  task automatic stop;
    hi(1'b0);
    sda_oe = 1'b0;
    #T;
  endtask
  task automatic xfer(input logic [7:0] d, input logic m,
    output logic [7:0] q, output logic k);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(m, k);
  endtask
endmodule // two_wire_master_model
`default_nettype wire

// file: two_wire_slave_engine_bench.sv
// Self-checking bench: CPU pulses on clk, bus traffic from the model.
// Assumes the engine, its package, the checker and the master model.
`timescale 1ns/100ps
`default_nettype none
module two_wire_slave_engine_bench;
  logic clk, rst_n, link_clk, module_enable_bit, ack_enable_bit;
  logic begin_request_bit, general_call_enable, arb_lost;
  logic data_write, event_clear, halt_clear, a;
  logic [6:0] own_address_register;
  logic [7:0] data_register_in, status_code_field, data_register_out, q;
  logic event_flag, halt_request_flag, begin_pending;
  logic scl_out, scl_oe, sda_out, sda_oe, m_scl_oe, m_sda_oe;
  int err_count, num_checks, cyc;
  wire scl = ~(scl_oe | m_scl_oe);
  wire sda = ~(sda_oe | m_sda_oe);
  two_wire_slave_engine u_dut (.clk, .rst_n, .link_clk, .module_enable_bit,
    .ack_enable_bit, .begin_request_bit, .general_call_enable,
    .own_address_register, .arb_lost, .data_register_in, .data_write,
    .event_clear, .halt_clear, .event_flag, .halt_request_flag,
    .status_code_field, .data_register_out, .begin_pending, .scl_in(scl),
    .scl_out, .scl_oe, .sda_in(sda), .sda_out, .sda_oe);
  two_wire_master_model u_master (.scl, .sda, .scl_oe(m_scl_oe),
    .sda_oe(m_sda_oe));
  // ----------------------------------------
  // Clocks, timeout and helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Odd offset keeps the link clock out of step with clk
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("Error %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic cpu(input logic w, c, h, input logic [7:0] b);
    @(posedge clk);
    data_write <= w;
    event_clear <= c;
    halt_clear <= h;
    data_register_in <= b;
    @(posedge clk);
    data_write <= 1'b0;
    event_clear <= 1'b0;
    halt_clear <= 1'b0;
  endtask
  task automatic clr(input logic h);
    cpu(1'b0, 1'b1, h, 8'h00);
  endtask
  task automatic wait_ev(input logic [7:0] e);
    int n;
    n = 0;
    while (event_flag !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, event_flag}, 8'h01);
    chk(status_code_field, e);
  endtask
  task automatic send(input logic [7:0] d);
    u_master.xfer(d, 1'b1, q, a);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rst_n, module_enable_bit, begin_request_bit, arb_lost} = 4'h0;
    {data_write, event_clear, halt_clear} = 3'h0;
    {ack_enable_bit, general_call_enable} = 2'h3;
    own_address_register = 7'h2a;
    data_register_in = 8'h00;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk) module_enable_bit <= 1'b1;
    repeat (8) @(negedge clk);
    chk(status_code_field, 8'hf8);
    u_master.start();
    send(8'h54);
    chk({7'h00, a}, 8'h00);
    wait_ev(two_wire_pkg::ST_WRITE_ACK);
    chk({7'h00, scl}, 8'h00);
    clr(1'b0);
    send(8'ha5);
    chk({7'h00, a}, 8'h00);
    wait_ev(two_wire_pkg::ST_RX_ACK);
    chk(data_register_out, 8'ha5);
    clr(1'b0);
    u_master.stop();
    wait_ev(two_wire_pkg::ST_STOP_RESTART);
    chk({7'h00, halt_request_flag}, 8'h01);
    clr(1'b1);
    $display("write test done");
    u_master.start();
    fork
      send(8'h55);
      begin
        wait_ev(two_wire_pkg::ST_READ_ACK);
        cpu(1'b1, 1'b0, 1'b0, 8'hc3);
      end
    join
    chk({7'h00, a}, 8'h00);
    u_master.xfer(8'hff, 1'b0, q, a);
    chk(q, 8'hc3);
    wait_ev(two_wire_pkg::ST_TX_ACK);
    chk({7'h00, scl}, 8'h00);
    @(posedge clk) ack_enable_bit <= 1'b0;
    cpu(1'b1, 1'b0, 1'b0, 8'h3c);
    u_master.xfer(8'hff, 1'b0, q, a);
    chk(q, 8'h3c);
    wait_ev(two_wire_pkg::ST_TX_LAST);
    @(posedge clk) ack_enable_bit <= 1'b1;
    clr(1'b0);
    u_master.stop();
    @(posedge clk) arb_lost <= 1'b1;
    u_master.start();
    fork
      send(8'h55);
      begin
        wait_ev(two_wire_pkg::ST_READ_ARB);
        cpu(1'b1, 1'b0, 1'b0, 8'h81);
      end
    join
    @(posedge clk) arb_lost <= 1'b0;
    u_master.xfer(8'hff, 1'b1, q, a);
    chk(q, 8'h81);
    wait_ev(two_wire_pkg::ST_TX_NACK);
    clr(1'b0);
    u_master.stop();
    repeat (20) @(negedge clk);
    chk({7'h00, halt_request_flag}, 8'h00);
    $display("read test done");
    u_master.start();
    send(8'h2a);
    chk({7'h00, a}, 8'h01);
    u_master.start();
    send(8'h00);
    chk({7'h00, a}, 8'h00);
    wait_ev(two_wire_pkg::ST_GC_ACK);
    clr(1'b0);
    u_master.start();
    wait_ev(two_wire_pkg::ST_STOP_RESTART);
    clr(1'b0);
    send(8'h54);
    wait_ev(two_wire_pkg::ST_WRITE_ACK);
    clr(1'b0);
    u_master.stop();
    wait_ev(two_wire_pkg::ST_STOP_RESTART);
    clr(1'b1);
    $display("restart test done");
    @(posedge clk) module_enable_bit <= 1'b0;
    u_master.start();
    send(8'h54);
    chk({7'h00, a}, 8'h01);
    chk(status_code_field, 8'ha0);
    u_master.stop();
    @(posedge clk) module_enable_bit <= 1'b1;
    repeat (8) @(posedge clk);
    u_master.start();
    send(8'h54);
    wait_ev(two_wire_pkg::ST_WRITE_ACK);
    clr(1'b0);
    u_master.stop();
    wait_ev(two_wire_pkg::ST_STOP_RESTART);
    clr(1'b1);
    @(posedge clk) begin_request_bit <= 1'b1;
    repeat (40) @(negedge clk);
    chk({7'h00, begin_pending}, 8'h01);
    $display("enable test done");
    conclude();
  end
endmodule // two_wire_slave_engine_bench
`default_nettype wire
